// >>> rtl/fpe_pkg.sv
package fpe_pkg;
    typedef logic [7:0] fpe_byte_t;
    typedef logic [1:0] fpe_addr_t;

    // register addresses on the plain port
    localparam fpe_addr_t FPE_ADDR_CTRL = 2'h0;
    localparam fpe_addr_t FPE_ADDR_STAT = 2'h1;
    localparam fpe_addr_t FPE_ADDR_LOW  = 2'h2;
    localparam fpe_addr_t FPE_ADDR_HIGH = 2'h3;

    // mode control field positions
    localparam int FPE_HWP_BIT  = 7;
    localparam int FPE_SWP_BIT  = 6;
    localparam int FPE_ESU_BIT  = 5;
    localparam int FPE_PSU_BIT  = 4;
    localparam int FPE_ECHK_BIT = 3;
    localparam int FPE_PCHK_BIT = 2;
    localparam int FPE_EGO_BIT  = 1;
    localparam int FPE_PGO_BIT  = 0;
    // error status field position
    localparam int FPE_FLAG_BIT = 7;

    // reset values and masks
    localparam logic [6:0] FPE_CTRL_RST  = 7'h00;
    localparam logic [5:0] FPE_OPS_CLR   = 6'h00;
    localparam fpe_byte_t  FPE_BLK_RST   = 8'h00;
    localparam fpe_byte_t  FPE_RD_IDLE   = 8'h00;
    localparam logic [6:0] FPE_STAT_RSVD = 7'h00;
    localparam fpe_byte_t  FPE_LOW_MASK  = 8'hFF;
    localparam fpe_byte_t  FPE_HIGH_MASK = 8'h03;

    // true when more than one bit of v is set
    function automatic logic fpe_multi_bit(input fpe_byte_t v);
        return (v & (v - 8'h01)) != 8'h00;
    endfunction : fpe_multi_bit
endpackage : fpe_pkg

// >>> rtl/fpe_blk_sel.sv
`timescale 1ns/1ns
`default_nettype none

module fpe_blk_sel #(
    parameter fpe_pkg::fpe_byte_t VALID_MASK = 8'hFF
) (
    // clock and reset
    input  wire logic               clk_in,
    input  wire logic               rst_b_in,
    // control
    input  wire logic               permit_in,
    input  wire logic               wr_in,
    input  wire fpe_pkg::fpe_byte_t wdata_in,
    // selection
    output var  fpe_pkg::fpe_byte_t sel_out
);
    import fpe_pkg::*;

    typedef struct packed {
        fpe_byte_t sel_r;
    } fpe_blk_state_t;

    fpe_blk_state_t q;
    fpe_blk_state_t d;
    fpe_byte_t      wval;

    always_comb begin
        d    = q;
        wval = wdata_in & VALID_MASK;
        if (!permit_in) begin
            d.sel_r = FPE_BLK_RST;
        end else if (wr_in) begin
            // several blocks at once wipes the whole selection
            d.sel_r = fpe_multi_bit(wval) ? FPE_BLK_RST : wval;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            q.sel_r <= FPE_BLK_RST;
        end else begin
            q <= d;
        end
    end

    assign sel_out = q.sel_r;

    chk_held_zero: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        !permit_in |=> sel_out == FPE_BLK_RST)
        else $error("selection not zero while write permit is low");

    chk_never_multi: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        !fpe_multi_bit(sel_out))
        else $error("more than one erase block selected");

    chk_single_taken: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        permit_in && wr_in && !fpe_multi_bit(wdata_in & VALID_MASK)
        |=> sel_out == $past(wdata_in & VALID_MASK))
        else $error("single block write not stored");
endmodule : fpe_blk_sel

`default_nettype wire

// >>> rtl/fpe_err_flag.sv
`timescale 1ns/1ns
`default_nettype none

module fpe_err_flag (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_b_in,
    // failure report
    input  wire logic fail_in,
    input  wire logic active_in,
    // flag
    output var  logic flag_out
);
    import fpe_pkg::*;

    typedef struct packed {
        logic flag_r;
    } fpe_err_state_t;

    fpe_err_state_t q;
    fpe_err_state_t d;

    always_comb begin
        d = q;
        // sticky: only reset clears it
        if (fail_in && active_in) begin
            d.flag_r = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            q.flag_r <= 1'b0;
        end else begin
            q <= d;
        end
    end

    assign flag_out = q.flag_r;

    chk_flag_sets: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        fail_in && active_in |=> flag_out)
        else $error("failure did not raise the error flag");

    chk_flag_sticky: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        $rose(flag_out) |-> flag_out [*4])
        else $error("error flag dropped without reset");

    chk_flag_cause: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        $rose(flag_out) |-> $past(fail_in && active_in))
        else $error("error flag rose without a failure");
endmodule : fpe_err_flag

`default_nettype wire

// >>> rtl/fpe_top.sv
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module fpe_top (
    // clock and reset
    input  wire logic               clk_in,
    input  wire logic               rst_b_in,
    // register port
    input  wire fpe_pkg::fpe_addr_t addr_in,
    input  wire fpe_pkg::fpe_byte_t wdata_in,
    input  wire logic               wr_in,
    input  wire logic               rd_in,
    output var  fpe_pkg::fpe_byte_t rdata_out,
    // pins and array feedback
    input  wire logic               hw_write_permit_in,
    input  wire logic               op_fail_in,
    // flash state
    output var  logic               erase_setup_out,
    output var  logic               program_setup_out,
    output var  logic               erase_check_out,
    output var  logic               program_check_out,
    output var  logic               erase_mode_out,
    output var  logic               program_mode_out,
    output var  logic               error_protect_out,
    // erase block selection
    output var  fpe_pkg::fpe_byte_t sel_low_out,
    output var  fpe_pkg::fpe_byte_t sel_high_out
);
    import fpe_pkg::*;

    // one strobe aimed at one register address
    function automatic logic fpe_hit(input logic      strobe,
                                     input fpe_addr_t a,
                                     input fpe_addr_t target);
        return strobe && (a == target);
    endfunction : fpe_hit

    typedef struct packed {
        logic [6:0] ctrl_r;
        fpe_byte_t  rdata_r;
        logic       emode_r;
        logic       pmode_r;
    } fpe_top_state_t;

    fpe_top_state_t q;
    fpe_top_state_t d;

    logic      wr_ctrl;
    logic      wr_low;
    logic      wr_high;
    logic      flag;
    logic      permit;
    logic      permit_nxt;
    fpe_byte_t sel_low;
    fpe_byte_t sel_high;
    fpe_byte_t ctrl_view;
    fpe_byte_t stat_view;

    assign wr_ctrl    = fpe_hit(wr_in, addr_in, FPE_ADDR_CTRL);
    assign wr_low     = fpe_hit(wr_in, addr_in, FPE_ADDR_LOW);
    assign wr_high    = fpe_hit(wr_in, addr_in, FPE_ADDR_HIGH);
    assign permit     = q.ctrl_r[FPE_SWP_BIT];
    // selections see the coming permit, so they empty on the same edge
    // that clears it and never show stale blocks beside a low permit
    assign permit_nxt = d.ctrl_r[FPE_SWP_BIT];

    // pin level sits above the stored bits
    assign ctrl_view = {hw_write_permit_in, q.ctrl_r};
    assign stat_view = {flag, FPE_STAT_RSVD};

    always_comb begin
        d         = q;
        d.rdata_r = FPE_RD_IDLE;

        if (wr_ctrl) begin
            d.ctrl_r[FPE_SWP_BIT] = wdata_in[FPE_SWP_BIT];
            if (permit) begin
                d.ctrl_r[5:0] = wdata_in[5:0];
            end else begin
                // clearing is still allowed, setting is not
                d.ctrl_r[5:0] = q.ctrl_r[5:0] & wdata_in[5:0];
            end
        end

        // error protection drops every setup, check and go bit
        if (flag) begin
            d.ctrl_r[5:0] = FPE_OPS_CLR;
        end

        // modes follow the next control value, one cycle behind a write
        d.emode_r = d.ctrl_r[FPE_EGO_BIT]
                  && d.ctrl_r[FPE_SWP_BIT]
                  && d.ctrl_r[FPE_ESU_BIT]
                  && hw_write_permit_in
                  && !flag;
        d.pmode_r = d.ctrl_r[FPE_PGO_BIT]
                  && d.ctrl_r[FPE_SWP_BIT]
                  && d.ctrl_r[FPE_PSU_BIT]
                  && hw_write_permit_in
                  && !flag;

        if (rd_in) begin
            case (addr_in)
                FPE_ADDR_CTRL: begin
                    d.rdata_r = ctrl_view;
                end
                FPE_ADDR_STAT: begin
                    d.rdata_r = stat_view;
                end
                FPE_ADDR_LOW: begin
                    d.rdata_r = sel_low;
                end
                FPE_ADDR_HIGH: begin
                    d.rdata_r = sel_high;
                end
                default: begin
                    d.rdata_r = FPE_RD_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            q.ctrl_r  <= FPE_CTRL_RST;
            q.rdata_r <= FPE_RD_IDLE;
            q.emode_r <= 1'b0;
            q.pmode_r <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // writes to the status address fall through: it has no storage
    fpe_blk_sel #(
        .VALID_MASK (FPE_LOW_MASK)
    ) u_sel_low (
        .clk_in    (clk_in),
        .rst_b_in  (rst_b_in),
        .permit_in (permit_nxt),
        .wr_in     (wr_low),
        .wdata_in  (wdata_in),
        .sel_out   (sel_low)
    );

    fpe_blk_sel #(
        .VALID_MASK (FPE_HIGH_MASK)
    ) u_sel_high (
        .clk_in    (clk_in),
        .rst_b_in  (rst_b_in),
        .permit_in (permit_nxt),
        .wr_in     (wr_high),
        .wdata_in  (wdata_in),
        .sel_out   (sel_high)
    );

    // a failure only counts while a program or erase is under way
    fpe_err_flag u_err (
        .clk_in    (clk_in),
        .rst_b_in  (rst_b_in),
        .fail_in   (op_fail_in),
        .active_in (q.emode_r || q.pmode_r),
        .flag_out  (flag)
    );

    assign rdata_out         = q.rdata_r;
    assign erase_setup_out   = q.ctrl_r[FPE_ESU_BIT];
    assign program_setup_out = q.ctrl_r[FPE_PSU_BIT];
    assign erase_check_out   = q.ctrl_r[FPE_ECHK_BIT];
    assign program_check_out = q.ctrl_r[FPE_PCHK_BIT];
    assign erase_mode_out    = q.emode_r;
    assign program_mode_out  = q.pmode_r;
    assign error_protect_out = flag;
    assign sel_low_out       = sel_low;
    assign sel_high_out      = sel_high;

    // read answers stand exactly one cycle after the strobe
    chk_pin_readback: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        rd_in && addr_in == FPE_ADDR_CTRL
        |=> rdata_out[FPE_HWP_BIT] == $past(hw_write_permit_in))
        else $error("control bit 7 does not show the pin level");

    chk_permit_stored: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        wr_ctrl |=> q.ctrl_r[FPE_SWP_BIT] == $past(wdata_in[FPE_SWP_BIT]))
        else $error("software permit bit not stored");

    chk_refuse_set: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        wr_ctrl && !permit
        |=> (q.ctrl_r[5:0] & ~$past(q.ctrl_r[5:0])) == FPE_OPS_CLR)
        else $error("control bit set while software permit low");

    chk_setup_follow: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        wr_ctrl && permit && !flag
        |=> erase_setup_out == $past(wdata_in[FPE_ESU_BIT])
            && program_setup_out == $past(wdata_in[FPE_PSU_BIT]))
        else $error("setup state does not follow its bit");

    chk_check_follow: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        wr_ctrl && permit && !flag
        |=> erase_check_out == $past(wdata_in[FPE_ECHK_BIT])
            && program_check_out == $past(wdata_in[FPE_PCHK_BIT]))
        else $error("verify mode does not follow its bit");

    chk_erase_needs: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        erase_mode_out
        |-> q.ctrl_r[FPE_SWP_BIT] && q.ctrl_r[FPE_ESU_BIT]
            && q.ctrl_r[FPE_EGO_BIT])
        else $error("erase mode without permit, setup and erase bit");

    chk_erase_enter: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        wr_ctrl && permit && !flag && hw_write_permit_in
        && wdata_in[FPE_SWP_BIT] && wdata_in[FPE_ESU_BIT]
        && wdata_in[FPE_EGO_BIT]
        |=> erase_mode_out)
        else $error("erase mode not entered");

    chk_erase_cancel: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        wr_ctrl && !wdata_in[FPE_EGO_BIT] |=> !erase_mode_out)
        else $error("clearing the erase bit left erase mode on");

    chk_prog_needs: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        program_mode_out
        |-> q.ctrl_r[FPE_SWP_BIT] && q.ctrl_r[FPE_PSU_BIT]
            && q.ctrl_r[FPE_PGO_BIT])
        else $error("program mode without permit, setup and program bit");

    chk_prog_enter: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        wr_ctrl && permit && !flag && hw_write_permit_in
        && wdata_in[FPE_SWP_BIT] && wdata_in[FPE_PSU_BIT]
        && wdata_in[FPE_PGO_BIT]
        |=> program_mode_out)
        else $error("program mode not entered");

    chk_prog_cancel: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        wr_ctrl && !wdata_in[FPE_PGO_BIT] |=> !program_mode_out)
        else $error("clearing the program bit left program mode on");

    // the pin gates both modes as well, one cycle behind its level
    chk_pin_gate: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        !hw_write_permit_in |=> !erase_mode_out && !program_mode_out)
        else $error("mode active although the write-permit pin was low");

    // protection wipes the request bits in every cycle that it stands
    chk_protect_off: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        flag |=> !erase_mode_out && !program_mode_out
                 && q.ctrl_r[5:0] == FPE_OPS_CLR)
        else $error("operation still active under error protection");

    chk_flag_kept: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        error_protect_out |=> error_protect_out)
        else $error("error protection left without reset");

    chk_status_read: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        rd_in && addr_in == FPE_ADDR_STAT
        |=> rdata_out == {$past(flag), FPE_STAT_RSVD})
        else $error("status read shows wrong flag or reserved bits");

    chk_ctrl_read: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        fpe_hit(rd_in, addr_in, FPE_ADDR_CTRL)
        |=> rdata_out[6:0] == $past(q.ctrl_r))
        else $error("control read does not show the stored bits");

    chk_read_once: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        !rd_in |=> rdata_out == FPE_RD_IDLE)
        else $error("read data stood beyond its cycle");

    // with no write and no error the stored levels must not drift
    chk_levels_hold: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        !wr_ctrl && !flag |=> q.ctrl_r == $past(q.ctrl_r))
        else $error("control bits changed without a write");

    chk_sel_cleared: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        !permit |-> sel_low_out == FPE_BLK_RST
                    && sel_high_out == FPE_BLK_RST)
        else $error("block selection not held zero");

    // a selection only moves on its own write or on a permit drop
    chk_low_hold: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        permit_nxt && !wr_low |=> sel_low_out == $past(sel_low_out))
        else $error("low block selection changed without a write");

    chk_high_hold: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        permit_nxt && !wr_high |=> sel_high_out == $past(sel_high_out))
        else $error("high block selection changed without a write");

    chk_low_read: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        fpe_hit(rd_in, addr_in, FPE_ADDR_LOW)
        |=> rdata_out == $past(sel_low_out))
        else $error("low block read does not show the selection");

    chk_high_read: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        fpe_hit(rd_in, addr_in, FPE_ADDR_HIGH)
        |=> rdata_out == $past(sel_high_out))
        else $error("high block read does not show the selection");

    // only two blocks live in the high register
    chk_high_mask: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        (sel_high_out & ~FPE_HIGH_MASK) == FPE_BLK_RST)
        else $error("reserved high selection bit set");
endmodule : fpe_top

`default_nettype wire

// >>> testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb;
    import fpe_pkg::*;

    logic      clk_in             = 1'b0;
    logic      rst_b_in           = 1'b0;
    fpe_addr_t addr_in            = FPE_ADDR_CTRL;
    fpe_byte_t wdata_in           = 8'h00;
    logic      wr_in              = 1'b0;
    logic      rd_in              = 1'b0;
    logic      hw_write_permit_in = 1'b0;
    logic      op_fail_in         = 1'b0;
    fpe_byte_t rdata_out;
    logic      erase_setup_out;
    logic      program_setup_out;
    logic      erase_check_out;
    logic      program_check_out;
    logic      erase_mode_out;
    logic      program_mode_out;
    logic      error_protect_out;
    fpe_byte_t sel_low_out;
    fpe_byte_t sel_high_out;
    fpe_byte_t rd_val;
    int        error_cnt          = 0;
    int        comparisons        = 0;
    int        cycle_cnt          = 0;
    // setup, check and mode outputs packed for one compare
    wire logic [7:0] st = {2'h0, erase_setup_out, program_setup_out,
        erase_check_out, program_check_out, erase_mode_out, program_mode_out};

    fpe_top i_fpe_top (
        .clk_in             (clk_in),
        .rst_b_in           (rst_b_in),
        .addr_in            (addr_in),
        .wdata_in           (wdata_in),
        .wr_in              (wr_in),
        .rd_in              (rd_in),
        .rdata_out          (rdata_out),
        .hw_write_permit_in (hw_write_permit_in),
        .op_fail_in         (op_fail_in),
        .erase_setup_out    (erase_setup_out),
        .program_setup_out  (program_setup_out),
        .erase_check_out    (erase_check_out),
        .program_check_out  (program_check_out),
        .erase_mode_out     (erase_mode_out),
        .program_mode_out   (program_mode_out),
        .error_protect_out  (error_protect_out),
        .sel_low_out        (sel_low_out),
        .sel_high_out       (sel_high_out)
    );

    always #10 clk_in = ~clk_in;

    // whole run is about 120 cycles; ceiling of 5000 leaves wide margin
    always @(posedge clk_in) begin
        cycle_cnt <= cycle_cnt + 1;
        if (cycle_cnt == 5000) begin
            error_cnt = error_cnt + 1;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string name, input fpe_byte_t seen,
                       input fpe_byte_t exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // outputs are checked 1 ns after the taking edge, once updates landed
    task automatic wr(input fpe_addr_t a, input fpe_byte_t d);
        @(posedge clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clk_in);
        wr_in    <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input fpe_addr_t a, output fpe_byte_t d);
        @(posedge clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_in);
        rd_in   <= 1'b0;
        #1;
        d = rdata_out;
    endtask : rd

    task automatic do_reset();
        @(posedge clk_in);
        rst_b_in <= 1'b0;
        repeat (16) @(posedge clk_in);
        rst_b_in <= 1'b1;
        #1;
    endtask : do_reset

    task automatic t_reset_values();
        chk("modes", st, 8'h00);
        chk("flag", {7'h00, error_protect_out}, 8'h00);
        rd(FPE_ADDR_CTRL, rd_val);
        chk("ctrl pin low", rd_val, 8'h00);
        @(posedge clk_in);
        hw_write_permit_in <= 1'b1;
        rd(FPE_ADDR_CTRL, rd_val);
        chk("ctrl pin high", rd_val, 8'h80);
        rd(FPE_ADDR_STAT, rd_val);
        chk("status", rd_val, 8'h00);
    endtask : t_reset_values

    task automatic t_refused();
        // stored permit is low, so every set below is dropped
        wr(FPE_ADDR_CTRL, 8'h3F);
        chk("ctrl no permit", st, 8'h00);
        wr(FPE_ADDR_LOW, 8'h01);
        chk("low no permit", sel_low_out, 8'h00);
        wr(FPE_ADDR_HIGH, 8'h01);
        chk("high no permit", sel_high_out, 8'h00);
        rd(FPE_ADDR_CTRL, rd_val);
        chk("ctrl readback", rd_val, 8'h80);
    endtask : t_refused

    task automatic t_setup_check();
        wr(FPE_ADDR_CTRL, 8'h40);
        wr(FPE_ADDR_CTRL, 8'h7C);
        chk("setup check on", st, 8'h3C);
        rd(FPE_ADDR_CTRL, rd_val);
        chk("ctrl 7C", rd_val, 8'hFC);
        wr(FPE_ADDR_CTRL, 8'h40);
        chk("setup check off", st, 8'h00);
    endtask : t_setup_check

    task automatic t_go_bits();
        // go bit without its setup bit must not start a mode
        wr(FPE_ADDR_CTRL, 8'h43);
        chk("go no setup", st, 8'h00);
        wr(FPE_ADDR_CTRL, 8'h60);
        wr(FPE_ADDR_CTRL, 8'h62);
        chk("erase mode", st, 8'h22);
        wr(FPE_ADDR_CTRL, 8'h60);
        chk("erase cancel", st, 8'h20);
        // pin low blocks erase mode even with setup and erase bit set
        @(posedge clk_in);
        hw_write_permit_in <= 1'b0;
        wr(FPE_ADDR_CTRL, 8'h62);
        chk("erase pin low", st, 8'h20);
        @(posedge clk_in);
        hw_write_permit_in <= 1'b1;
        wr(FPE_ADDR_CTRL, 8'h60);
        wr(FPE_ADDR_CTRL, 8'h50);
        wr(FPE_ADDR_CTRL, 8'h51);
        chk("program mode", st, 8'h11);
        wr(FPE_ADDR_CTRL, 8'h50);
        chk("program cancel", st, 8'h10);
        wr(FPE_ADDR_CTRL, 8'h40);
    endtask : t_go_bits

    task automatic t_blocks();
        wr(FPE_ADDR_LOW, 8'h80);
        chk("low single", sel_low_out, 8'h80);
        rd(FPE_ADDR_LOW, rd_val);
        chk("low readback", rd_val, 8'h80);
        wr(FPE_ADDR_LOW, 8'h11);
        chk("low multi", sel_low_out, 8'h00);
        wr(FPE_ADDR_HIGH, 8'h02);
        chk("high single", sel_high_out, 8'h02);
        rd(FPE_ADDR_HIGH, rd_val);
        chk("high readback", rd_val, 8'h02);
        wr(FPE_ADDR_HIGH, 8'h03);
        chk("high multi", sel_high_out, 8'h00);
        wr(FPE_ADDR_LOW, 8'h01);
        wr(FPE_ADDR_HIGH, 8'h01);
        wr(FPE_ADDR_CTRL, 8'h00);
        chk("low permit off", sel_low_out, 8'h00);
        chk("high permit off", sel_high_out, 8'h00);
        rd(FPE_ADDR_LOW, rd_val);
        chk("low read permit off", rd_val, 8'h00);
    endtask : t_blocks

    task automatic t_error();
        wr(FPE_ADDR_CTRL, 8'h40);
        @(posedge clk_in);
        op_fail_in <= 1'b1;
        @(posedge clk_in);
        op_fail_in <= 1'b0;
        #1;
        chk("fail idle", {7'h00, error_protect_out}, 8'h00);
        wr(FPE_ADDR_CTRL, 8'h50);
        wr(FPE_ADDR_CTRL, 8'h51);
        @(posedge clk_in);
        op_fail_in <= 1'b1;
        @(posedge clk_in);
        op_fail_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        #1;
        chk("flag set", {7'h00, error_protect_out}, 8'h01);
        chk("protected", st, 8'h00);
        rd(FPE_ADDR_STAT, rd_val);
        chk("status flag", rd_val, 8'h80);
        // flag is sticky until reset, so retry a program start
        wr(FPE_ADDR_CTRL, 8'h51);
        #20;
        chk("still protected", st, 8'h00);
        do_reset();
        chk("flag after reset", {7'h00, error_protect_out}, 8'h00);
    endtask : t_error

    initial begin
        do_reset();
        t_reset_values();
        t_refused();
        t_setup_check();
        t_go_bits();
        t_blocks();
        t_error();
        test_done();
    end
endmodule : tb

`default_nettype wire
